//--- cpm_pkg.sv
// shared constants and types for the can power-mode and bit-timing block
`default_nettype none
package cpm_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] OFS_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_CTRL1 = 8'h04;
  localparam logic [7:0] OFS_BTIM0 = 8'h08;
  localparam logic [7:0] OFS_BTIM1 = 8'h0C;
  localparam logic [7:0] OFS_STAT  = 8'h10;
  // ==========================================================
  // module_control_0 fields
  localparam int B_SLEEP_REQ = 0;
  localparam int B_INIT_HOLD = 1;
  localparam int B_STOP_WAIT = 2;
  localparam int B_WAKE_FILT = 3;
  localparam int B_TLINK_EN  = 4;
  localparam int B_WAKE_IE   = 5;
  localparam int B_SLEEP_ACK = 8;
  localparam logic RST_INIT_HOLD = 1'b1;
  // module_control_1 fields
  localparam int B_CLK_SRC = 0;
  // ==========================================================
  // bit timing fields, each holding its count minus one (prescaler in source ticks, the others in quanta)
  localparam int PRESC_LSB = 0;
  localparam int PRESC_W   = 6;
  localparam int JUMP_LSB  = 6;
  localparam int JUMP_W    = 2;
  localparam int PH1_LSB   = 0;
  localparam int PH1_W     = 4;
  localparam int PH2_LSB   = 4;
  localparam int PH2_W     = 3;
  localparam int POS_W     = 5;
  // ==========================================================
  // status fields
  localparam int ST_MODE_LSB = 0;
  localparam int ST_BUS_ON   = 2;
  localparam int ST_TLINK    = 3;
  localparam int ST_TXE_LSB  = 4;
  localparam int TX_BUFS     = 3;
  // ==========================================================
  // timing
  localparam int CLK_MHZ       = 250;
  localparam int WAKE_FILT_NS  = 2000;
  localparam int WAKE_FILT_CYC = (WAKE_FILT_NS * CLK_MHZ + 999) / 1000;
  localparam int FILT_W        = 10;
  localparam int IDLE_BITS     = 11;
  localparam int IDLE_W        = 4;
  // ==========================================================
  // modes and sleep handshake states
  typedef enum logic [1:0] {
    CPM_NORMAL, CPM_SLEEP, CPM_INIT, CPM_OFF
  } cpm_mode_t;
  typedef enum logic [1:0] {
    SLP_AWAKE, SLP_PEND, SLP_ASLEEP
  } cpm_slp_t;
endpackage : cpm_pkg
`default_nettype wire

//--- cpm_tim_if.sv
// timing configuration and ticks between the controller and bit timer
`default_nettype none
interface cpm_tim_if;
  logic                         srcTick;
  logic                         halt;
  logic                         rxBit;
  logic [cpm_pkg::PRESC_W-1:0]  presc;
  logic [cpm_pkg::PH1_W-1:0]    ph1;
  logic [cpm_pkg::PH2_W-1:0]    ph2;
  logic [cpm_pkg::JUMP_W-1:0]   jump;
  logic                         tqTick;
  logic                         bitTick;
  logic                         sampleTick;
  modport ctl (output srcTick, halt, rxBit, presc, ph1, ph2, jump,
               input  tqTick, bitTick, sampleTick);
  modport tim (input  srcTick, halt, rxBit, presc, ph1, ph2, jump,
               output tqTick, bitTick, sampleTick);
endinterface : cpm_tim_if
`default_nettype wire

//--- cpm_btim.sv
// prescaler and bit-time sequencer producing quantum, bit and sample ticks
`default_nettype none
module cpm_btim (
  input wire logic clk,
  input wire logic rst,
  cpm_tim_if.tim   t
);
  logic [cpm_pkg::PRESC_W-1:0] pre_r;
  logic [cpm_pkg::POS_W-1:0]   pos_r;
  logic [cpm_pkg::POS_W-1:0]   ext_r;
  logic [cpm_pkg::POS_W-1:0]   seg1End;
  logic [cpm_pkg::POS_W-1:0]   bitEnd;
  logic                        tq;
  logic                        rxPrev_r;
  logic                        fallEdge;

  // ==========================================================
  // quantum prescaler
  assign tq = t.srcTick && (pre_r == t.presc) && !t.halt;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_r <= '0;
    end else if (t.halt) begin
      pre_r <= '0;
    end else if (t.srcTick) begin
      pre_r <= tq ? '0 : pre_r + 1'b1;
    end
  end

  // ==========================================================
  // bit sequencer: sync quantum, segment 1, segment 2
  assign seg1End = cpm_pkg::POS_W'(t.ph1) + 5'h01 + ext_r;
  assign bitEnd  = seg1End + cpm_pkg::POS_W'(t.ph2) + 5'h01;
  assign fallEdge = rxPrev_r && !t.rxBit;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxPrev_r <= 1'b1;
    end else begin
      rxPrev_r <= t.rxBit;
    end
  end

  // jump is applied whole to an edge in segment 1; an edge in segment 2 simply ends the bit early
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pos_r <= '0;
      ext_r <= '0;
    end else if (t.halt) begin
      pos_r <= '0;
      ext_r <= '0;
    end else if (fallEdge && pos_r != '0 && pos_r <= seg1End
                 && ext_r == '0) begin
      ext_r <= cpm_pkg::POS_W'(t.jump) + 5'h01;
    end else if (fallEdge && pos_r > seg1End) begin
      pos_r <= bitEnd;
    end else if (tq) begin
      if (pos_r == bitEnd) begin
        pos_r <= '0;
        ext_r <= '0;
      end else begin
        pos_r <= pos_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      t.tqTick     <= 1'b0;
      t.bitTick    <= 1'b0;
      t.sampleTick <= 1'b0;
    end else begin
      t.tqTick     <= tq;
      t.bitTick    <= tq && pos_r == bitEnd;
      t.sampleTick <= tq && pos_r == seg1End;
    end
  end
endmodule : cpm_btim
`default_nettype wire

//--- cpm_top.sv
// power modes, sleep handshake, wake-up, timer link and apb registers
`default_nettype none
// What this block does
// - sleep and init stop protocol clocks; clocks-off stops everything
// - mode comes from cpu state, stop-in-wait, sleep ack, init hold
// - wake-up interrupt only with sleep ack and wake enable both set
// - sleep waits until every transmit buffer reports empty
// - sleep waits for receive to finish; idle controller sleeps at once
// - in sleep the ack flag stays set and transmit pin recessive
// - no buffer copy or abort in sleep; buffer access still allowed
// - bus-off recovery count pauses in sleep and resumes after
// - sleep ends on bus activity, request clear or init hold set
// - clearing sleep request is ignored until sleep is acknowledged
// - after wake, eleven recessive bits are needed before joining
// - deferred copies, aborts and transmissions run after wake
// - init hold halts traffic at once; registers stay writable
// - clocks-off aborts activity, forces recessive, blocks registers
// - wake filter bit low-pass filters the receive pin in sleep
// - one bit-time timer pulse after each valid end of frame
// - timer link drives capture channel 4 or 5 per instance
// - clock source select picks oscillator or system clock tick
// - prescaler makes the quantum; sync segment is one quantum
// - segment 1 is 1-16, segment 2 is 1-8, jump 1-4 quanta
module cpm_top #(
  parameter int INSTANCE = 0
) (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  output var  logic [31:0]                 prdata,
  output logic                             pready,
  output var  logic                        pslverr,
  input  wire logic                        cpuStop,
  input  wire logic                        cpuWait,
  input  wire logic                        oscTick,
  input  wire logic                        sysTick,
  input  wire logic                        receivePin,
  output var  logic                        transmitPin,
  input  wire logic                        protoTxd,
  input  wire logic                        txBusy,
  input  wire logic                        rxBusy,
  input  wire logic                        busOff,
  input  wire logic                        frameEof,
  input  wire logic [cpm_pkg::TX_BUFS-1:0] txEmpty,
  output var  logic                        sleepAck,
  output var  logic [1:0]                  modeOut,
  output var  logic                        protoClkEn,
  output var  logic                        regClkEn,
  output var  logic                        deferAllow,
  output var  logic                        busOffCountEn,
  output var  logic                        wakeIrq,
  output var  logic                        timerCh4,
  output var  logic                        timerCh5,
  output logic                             bitTick,
  output logic                             sampleTick,
  output var  logic                        rxData
);
  // ==========================================================
  // declarations
  cpm_pkg::cpm_mode_t mode;
  cpm_pkg::cpm_mode_t mode_r;
  cpm_pkg::cpm_slp_t  slp_r;
  logic sleepReq_r;
  logic initHold_r;
  logic stopWait_r;
  logic wakeFilt_r;
  logic tlinkEn_r;
  logic wakeIe_r;
  logic clock_source_select_r;
  logic [cpm_pkg::PRESC_W-1:0] presc_r;
  logic [cpm_pkg::JUMP_W-1:0]  jump_r;
  logic [cpm_pkg::PH1_W-1:0]   ph1_r;
  logic [cpm_pkg::PH2_W-1:0]   ph2_r;
  logic rxMeta_r;
  logic rxSync_r;
  logic [cpm_pkg::FILT_W-1:0]  filt_r;
  logic [cpm_pkg::IDLE_W-1:0]  idle_r;
  logic busOn_r;
  logic tlink_r;
  logic offMode;
  logic asleep;
  logic wakeHit;
  logic wrEn;
  logic setup;
  logic hit;
  logic [31:0] rdNxt;

  cpm_tim_if tif ();

  // ==========================================================
  // receive pin synchroniser
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxMeta_r <= 1'b1;
      rxSync_r <= 1'b1;
    end else begin
      rxMeta_r <= receivePin;
      rxSync_r <= rxMeta_r;
    end
  end

  // ==========================================================
  // mode selection
  assign offMode = cpuStop || (cpuWait && stopWait_r);
  assign asleep  = (slp_r == cpm_pkg::SLP_ASLEEP);

  always_comb begin
    if (offMode) begin
      mode = cpm_pkg::CPM_OFF;
    end else if (asleep) begin
      mode = cpm_pkg::CPM_SLEEP;
    end else if (initHold_r) begin
      mode = cpm_pkg::CPM_INIT;
    end else begin
      mode = cpm_pkg::CPM_NORMAL;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_r <= cpm_pkg::CPM_INIT;
    end else begin
      mode_r <= mode;
    end
  end

  // ==========================================================
  // sleep handshake
  // power-down keeps the handshake frozen so sleep survives a cpu stop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slp_r <= cpm_pkg::SLP_AWAKE;
    end else if (!offMode) begin
      case (slp_r)
        cpm_pkg::SLP_AWAKE: begin
          if (sleepReq_r && !initHold_r) begin
            slp_r <= cpm_pkg::SLP_PEND;
          end
        end
        cpm_pkg::SLP_PEND: begin
          if (!sleepReq_r || initHold_r) begin
            slp_r <= cpm_pkg::SLP_AWAKE;
          end else if (&txEmpty && !txBusy && !rxBusy) begin
            slp_r <= cpm_pkg::SLP_ASLEEP;
          end
        end
        cpm_pkg::SLP_ASLEEP: begin
          if (!sleepReq_r || initHold_r || wakeHit) begin
            slp_r <= cpm_pkg::SLP_AWAKE;
          end
        end
        default: slp_r <= cpm_pkg::SLP_AWAKE;
      endcase
    end
  end

  // ==========================================================
  // wake-up detection with optional glitch filter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      filt_r <= '0;
    end else if (!asleep || rxSync_r || offMode) begin
      filt_r <= '0;
    end else if (filt_r != cpm_pkg::FILT_W'(cpm_pkg::WAKE_FILT_CYC)) begin
      filt_r <= filt_r + 1'b1;
    end
  end

  assign wakeHit = asleep && !offMode && !rxSync_r && (!wakeFilt_r ||
    filt_r == cpm_pkg::FILT_W'(cpm_pkg::WAKE_FILT_CYC - 1));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wakeIrq <= 1'b0;
    end else begin
      wakeIrq <= wakeHit && asleep && wakeIe_r;
    end
  end

  // ==========================================================
  // bus integration after wake or init
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idle_r  <= '0;
      busOn_r <= 1'b0;
    end else if (mode != cpm_pkg::CPM_NORMAL) begin
      idle_r  <= '0;
      busOn_r <= 1'b0;
    end else if (tif.sampleTick && !busOn_r) begin
      if (!rxSync_r) begin
        idle_r <= '0;
      end else if (idle_r == cpm_pkg::IDLE_W'(cpm_pkg::IDLE_BITS - 1)) begin
        busOn_r <= 1'b1;
      end else begin
        idle_r <= idle_r + 1'b1;
      end
    end
  end

  // ==========================================================
  // bit timer
  assign tif.srcTick = clock_source_select_r ? sysTick : oscTick;
  assign tif.halt    = (mode != cpm_pkg::CPM_NORMAL);
  assign tif.rxBit   = rxSync_r;
  assign tif.presc   = presc_r;
  assign tif.ph1     = ph1_r;
  assign tif.ph2     = ph2_r;
  assign tif.jump    = jump_r;
  assign bitTick     = tif.bitTick;
  assign sampleTick  = tif.sampleTick;

  cpm_btim u_btim (
    .clk (clk),
    .rst (rst),
    .t   (tif.tim)
  );

  // ==========================================================
  // outputs toward the protocol engine and pins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      transmitPin   <= 1'b1;
      sleepAck      <= 1'b0;
      modeOut       <= '0;
      protoClkEn    <= 1'b0;
      regClkEn      <= 1'b0;
      deferAllow    <= 1'b0;
      busOffCountEn <= 1'b0;
      rxData        <= 1'b1;
    end else begin
      transmitPin   <= (mode == cpm_pkg::CPM_NORMAL && busOn_r) ?
                       protoTxd : 1'b1;
      sleepAck      <= asleep;
      modeOut       <= mode;
      protoClkEn    <= (mode == cpm_pkg::CPM_NORMAL);
      regClkEn      <= (mode != cpm_pkg::CPM_OFF);
      deferAllow    <= (mode == cpm_pkg::CPM_NORMAL);
      busOffCountEn <= busOff && tif.sampleTick &&
                       mode == cpm_pkg::CPM_NORMAL;
      rxData        <= rxSync_r;
    end
  end

  // ==========================================================
  // timer link pulse, one bit long
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tlink_r <= 1'b0;
    end else if (mode != cpm_pkg::CPM_NORMAL) begin
      tlink_r <= 1'b0;
    end else if (frameEof) begin
      tlink_r <= 1'b1;
    end else if (tif.bitTick) begin
      tlink_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timerCh4 <= 1'b0;
      timerCh5 <= 1'b0;
    end else begin
      timerCh4 <= tlink_r && tlinkEn_r && INSTANCE == 0;
      timerCh5 <= tlink_r && tlinkEn_r && INSTANCE == 1;
    end
  end

  // ==========================================================
  // apb slave, zero wait states
  assign pready = 1'b1;
  assign setup  = psel && !penable;
  assign wrEn   = psel && penable && pwrite && !offMode;
  assign hit    = paddr == cpm_pkg::OFS_CTRL0 || paddr == cpm_pkg::OFS_CTRL1
               || paddr == cpm_pkg::OFS_BTIM0 || paddr == cpm_pkg::OFS_BTIM1
               || paddr == cpm_pkg::OFS_STAT;

  always_comb begin
    rdNxt = '0;
    case (paddr)
      cpm_pkg::OFS_CTRL0: begin
        rdNxt[cpm_pkg::B_SLEEP_REQ] = sleepReq_r;
        rdNxt[cpm_pkg::B_INIT_HOLD] = initHold_r;
        rdNxt[cpm_pkg::B_STOP_WAIT] = stopWait_r;
        rdNxt[cpm_pkg::B_WAKE_FILT] = wakeFilt_r;
        rdNxt[cpm_pkg::B_TLINK_EN]  = tlinkEn_r;
        rdNxt[cpm_pkg::B_WAKE_IE]   = wakeIe_r;
        rdNxt[cpm_pkg::B_SLEEP_ACK] = asleep;
      end
      cpm_pkg::OFS_CTRL1: rdNxt[cpm_pkg::B_CLK_SRC] = clock_source_select_r;
      cpm_pkg::OFS_BTIM0: begin
        rdNxt[cpm_pkg::PRESC_LSB +: cpm_pkg::PRESC_W] = presc_r;
        rdNxt[cpm_pkg::JUMP_LSB +: cpm_pkg::JUMP_W]   = jump_r;
      end
      cpm_pkg::OFS_BTIM1: begin
        rdNxt[cpm_pkg::PH1_LSB +: cpm_pkg::PH1_W] = ph1_r;
        rdNxt[cpm_pkg::PH2_LSB +: cpm_pkg::PH2_W] = ph2_r;
      end
      cpm_pkg::OFS_STAT: begin
        rdNxt[cpm_pkg::ST_MODE_LSB +: 2] = mode_r;
        rdNxt[cpm_pkg::ST_BUS_ON]        = busOn_r;
        rdNxt[cpm_pkg::ST_TLINK]         = tlink_r;
        rdNxt[cpm_pkg::ST_TXE_LSB +: cpm_pkg::TX_BUFS] = txEmpty;
      end
      default: rdNxt = '0;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= offMode ? '0 : rdNxt;
      pslverr <= !hit || offMode;
    end
  end

  // ==========================================================
  // control register writes
  // hardware clears the request on bus wake; a software write wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sleepReq_r <= 1'b0;
      initHold_r <= cpm_pkg::RST_INIT_HOLD;
      stopWait_r <= 1'b0;
      wakeFilt_r <= 1'b0;
      tlinkEn_r  <= 1'b0;
      wakeIe_r   <= 1'b0;
    end else begin
      if (wakeHit) begin
        sleepReq_r <= 1'b0;
      end
      if (wrEn && paddr == cpm_pkg::OFS_CTRL0) begin
        sleepReq_r <= pwdata[cpm_pkg::B_SLEEP_REQ] ||
                      (sleepReq_r && !asleep && !wakeHit);
        initHold_r <= pwdata[cpm_pkg::B_INIT_HOLD];
        stopWait_r <= pwdata[cpm_pkg::B_STOP_WAIT];
        wakeFilt_r <= pwdata[cpm_pkg::B_WAKE_FILT];
        tlinkEn_r  <= pwdata[cpm_pkg::B_TLINK_EN];
        wakeIe_r   <= pwdata[cpm_pkg::B_WAKE_IE];
      end
    end
  end

  // configuration is locked unless init hold is set
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clock_source_select_r <= 1'b0;
      presc_r  <= '0;
      jump_r   <= '0;
      ph1_r    <= '0;
      ph2_r    <= '0;
    end else if (wrEn && initHold_r) begin
      if (paddr == cpm_pkg::OFS_CTRL1) begin
        clock_source_select_r <= pwdata[cpm_pkg::B_CLK_SRC];
      end
      if (paddr == cpm_pkg::OFS_BTIM0) begin
        presc_r <= pwdata[cpm_pkg::PRESC_LSB +: cpm_pkg::PRESC_W];
        jump_r  <= pwdata[cpm_pkg::JUMP_LSB +: cpm_pkg::JUMP_W];
      end
      if (paddr == cpm_pkg::OFS_BTIM1) begin
        ph1_r <= pwdata[cpm_pkg::PH1_LSB +: cpm_pkg::PH1_W];
        ph2_r <= pwdata[cpm_pkg::PH2_LSB +: cpm_pkg::PH2_W];
      end
    end
  end
endmodule : cpm_top
`default_nettype wire

//--- cpm_can_node.sv
// far-side can node that holds the shared bus dominant on command
`default_nettype none
module cpm_can_node (
  input  wire logic        clk,
  input  wire logic        txPin,
  input  wire logic [15:0] domLen,
  input  wire logic        kick,
  output logic             busLine
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // wired-and bus; the pull-up makes it recessive once released
  logic [15:0] left_r = 16'h0000;
  always_ff @(posedge clk) begin
    if (kick) left_r <= domLen;
    else if (left_r != 16'h0000) left_r <= left_r - 16'h0001;
  end
  assign busLine = txPin & (left_r == 16'h0000);
endmodule : cpm_can_node
`default_nettype wire

//--- cpm_top_monitor.sv
// port checker for the power-mode and bit-timing block
`default_nettype none
module cpm_top_monitor #(
  parameter int INSTANCE = 0
) (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pslverr,
  input wire logic       cpuStop,
  input wire logic       rxBusy,
  input wire logic [2:0] txEmpty,
  input wire logic       transmitPin,
  input wire logic       sleepAck,
  input wire logic [1:0] modeOut,
  input wire logic       protoClkEn,
  input wire logic       regClkEn,
  input wire logic       deferAllow,
  input wire logic       busOffCountEn,
  input wire logic       wakeIrq,
  input wire logic       timerCh4,
  input wire logic       timerCh5,
  input wire logic       bitTick
);
  // ==========================================================
  // checks; mode register lags so low-power ones wait a cycle
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic lowPow_r, offPrev_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) {lowPow_r, offPrev_r} <= 2'h0;
    else {lowPow_r, offPrev_r} <= {modeOut != 2'h0, modeOut == 2'h3};
  end
  // ack and mode register on the same edge, so entry is the ack rise itself
  sequence s_enter;
    !sleepAck ##1 sleepAck && modeOut == 2'h1;
  endsequence
  chk_sleep_gate: assert property (
    s_enter |-> $past(txEmpty, 2) == 3'h7 && !$past(rxBusy, 2))
    else $error("sleep entered with work pending");
  chk_off_mode: assert property (cpuStop |-> ##[1:2] modeOut == 2'h3)
    else $error("stopped cpu gave no clocks-off");
  chk_ack_recess: assert property (sleepAck |-> transmitPin)
    else $error("dominant while asleep");
  chk_lowpow_tx: assert property (
    lowPow_r && modeOut != 2'h0 |-> transmitPin)
    else $error("dominant in low power");
  chk_lowpow_clk: assert property (
    lowPow_r && modeOut != 2'h0 |-> !protoClkEn && !deferAllow)
    else $error("protocol clock in low power");
  chk_off_regclk: assert property (offPrev_r && modeOut == 2'h3 |-> !regClkEn)
    else $error("register clock in clocks-off");
  chk_wake_irq: assert property (wakeIrq |-> sleepAck ##1 !wakeIrq)
    else $error("wake pulse without sleep");
  chk_busoff_hold: assert property (busOffCountEn |-> !sleepAck)
    else $error("bus-off count while asleep");
  chk_link_len: assert property ($fell(timerCh4) |-> $past(bitTick, 2))
    else $error("timer pulse not one bit");
  chk_link_chan: assert property (INSTANCE == 0 |-> !timerCh5)
    else $error("wrong timer channel");
  chk_off_err: assert property (
    psel && penable && $past(cpuStop) |-> pslverr)
    else $error("access allowed in clocks-off");
endmodule : cpm_top_monitor
`default_nettype wire

//--- cpm_top_tb.sv
// self-checking bench for the power-mode and bit-timing block
`default_nettype none
module cpm_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // signals and tasks; bit = 2 ticks * (1 + 4 + 3) quanta
  localparam int BIT_CYC = 2 * (1 + (3 + 1) + (2 + 1));
  typedef struct packed {
    logic w; logic [7:0] a; logic [31:0] d, x; logic e;
  } cpm_row_t;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, cpuStop = 1'b0, cpuWait = 1'b0;
  logic        oscTick = 1'b0, sysTick = 1'b1, protoTxd = 1'b1;
  logic        txBusy = 1'b0, rxBusy = 1'b0, busOff = 1'b0;
  logic        frameEof = 1'b0, kick = 1'b0, pready, pslverr, rdE;
  logic        receivePin, transmitPin, sleepAck, protoClkEn, regClkEn;
  logic        deferAllow, wakeIrq, busOffCountEn, timerCh4, timerCh5;
  logic        bitTick, sampleTick, rxData;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdQ;
  logic [2:0]  txEmpty = 3'h7;
  logic [15:0] domLen = 16'h0000;
  logic [1:0]  modeOut;
  int          badCount = 0, checkCount = 0, n, i;
  cpm_row_t    rows [10] = '{
    '{1'b0, 8'h00, 32'h0, 32'h2, 1'b0}, '{1'b1, 8'h08, 32'h41, 32'h0, 1'b0},
    '{1'b0, 8'h08, 32'h0, 32'h41, 1'b0}, '{1'b1, 8'h0C, 32'h23, 32'h0, 1'b0},
    '{1'b0, 8'h0C, 32'h0, 32'h23, 1'b0}, '{1'b1, 8'h04, 32'h1, 32'h0, 1'b0},
    '{1'b0, 8'h04, 32'h0, 32'h1, 1'b0}, '{1'b0, 8'h10, 32'h0, 32'h72, 1'b0},
    '{1'b0, 8'h14, 32'h0, 32'h0, 1'b1}, '{1'b1, 8'h14, 32'h5A, 32'h0, 1'b1}};
  cpm_top #(.INSTANCE(0)) u_cpm_top (.clk, .rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .cpuStop, .cpuWait,
    .oscTick, .sysTick, .receivePin, .transmitPin, .protoTxd, .txBusy,
    .rxBusy, .busOff, .frameEof, .txEmpty, .sleepAck, .modeOut, .protoClkEn,
    .regClkEn, .deferAllow, .busOffCountEn, .wakeIrq, .timerCh4, .timerCh5,
    .bitTick, .sampleTick, .rxData);
  cpm_can_node u_cpm_can_node (.clk, .txPin(transmitPin), .domLen, .kick,
    .busLine(receivePin));
  always #2 clk = ~clk;
  always @(posedge clk) oscTick <= ~oscTick;
  task automatic chkW(input logic [31:0] g, input logic [31:0] x);
    checkCount++;
    if (g !== x) begin
      badCount++;
      $display("ERROR t=%0t got %h exp %h", $time, g, x);
    end
  endtask : chkW
  task automatic chkB(input logic g, input logic x);
    chkW({31'h0, g}, {31'h0, x});
  endtask : chkB
  // extra edges after release let mode and ack registers settle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdQ = prdata;
    rdE = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : apb
  task automatic conclude;
    $display("checks %0d errors %0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  // ==========================================================
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (rows[k]) begin
      apb(rows[k].w, rows[k].a, rows[k].d);
      if (!rows[k].w) chkW(rdQ, rows[k].x);
      chkB(rdE, rows[k].e);
    end
    protoTxd <= 1'b0;
    apb(1'b1, 8'h00, 32'h10);
    chkW(32'(modeOut), 32'h0);
    chkB(protoClkEn, 1'b1);
    repeat (5 * BIT_CYC) @(posedge clk);
    chkB(transmitPin, 1'b1);
    @(posedge clk iff bitTick === 1'b1);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (bitTick !== 1'b1 && n < 99);
    chkW(32'(n), 32'(BIT_CYC));
    // sample point sits after sync plus segment 1 quanta
    repeat (2 * (1 + (3 + 1))) @(posedge clk);
    chkB(sampleTick, 1'b1);
    @(posedge clk iff bitTick === 1'b1);
    repeat (BIT_CYC - 1) @(posedge clk);
    frameEof <= 1'b1;
    @(posedge clk) frameEof <= 1'b0;
    n = 0;
    repeat (3 * BIT_CYC) begin
      @(posedge clk);
      if (timerCh4 === 1'b1) n++;
    end
    chkW(32'(n), 32'(BIT_CYC));
    repeat (5 * BIT_CYC) @(posedge clk);
    chkB(transmitPin, 1'b0);
    chkB(rxData, 1'b0);
    protoTxd <= 1'b1;
    busOff <= 1'b1;
    txEmpty <= 3'h6;
    rxBusy <= 1'b1;
    repeat (4) @(posedge clk);
    apb(1'b1, 8'h00, 32'h11);
    apb(1'b1, 8'h00, 32'h10);
    apb(1'b0, 8'h00, 32'h0);
    chkB(rdQ[0], 1'b1);
    chkB(sleepAck, 1'b0);
    txEmpty <= 3'h7;
    repeat (8) @(posedge clk);
    chkB(sleepAck, 1'b0);
    rxBusy <= 1'b0;
    for (i = 0; i < 40 && sleepAck !== 1'b1; i++) @(posedge clk);
    chkB(sleepAck, 1'b1);
    chkW(32'(modeOut), 32'h1);
    chkB(transmitPin, 1'b1);
    chkB(deferAllow, 1'b0);
    apb(1'b1, 8'h00, 32'h10);
    chkB(sleepAck, 1'b0);
    chkB(deferAllow, 1'b1);
    n = 0;
    repeat (2 * BIT_CYC) begin
      @(posedge clk);
      if (busOffCountEn === 1'b1) n++;
    end
    chkW(32'(n), 32'h2);
    apb(1'b1, 8'h00, 32'h39);
    for (i = 0; i < 40 && sleepAck !== 1'b1; i++) @(posedge clk);
    domLen <= 16'h0064;
    kick <= 1'b1;
    @(posedge clk) kick <= 1'b0;
    repeat (300) @(posedge clk);
    chkB(sleepAck, 1'b1);
    domLen <= 16'h02BC;
    kick <= 1'b1;
    @(posedge clk) kick <= 1'b0;
    for (i = 0; i < 900 && wakeIrq !== 1'b1; i++) @(posedge clk);
    chkB(wakeIrq, 1'b1);
    repeat (800) @(posedge clk);
    apb(1'b0, 8'h00, 32'h0);
    chkB(rdQ[0], 1'b0);
    apb(1'b1, 8'h00, 32'h01);
    for (i = 0; i < 40 && sleepAck !== 1'b1; i++) @(posedge clk);
    apb(1'b1, 8'h00, 32'h02);
    chkB(sleepAck, 1'b0);
    chkW(32'(modeOut), 32'h2);
    apb(1'b1, 8'h00, 32'h04);
    cpuWait <= 1'b1;
    repeat (3) @(posedge clk);
    chkW(32'(modeOut), 32'h3);
    chkB(regClkEn, 1'b0);
    apb(1'b1, 8'h00, 32'h00);
    chkB(rdE, 1'b1);
    cpuWait <= 1'b0;
    cpuStop <= 1'b1;
    repeat (3) @(posedge clk);
    chkW(32'(modeOut), 32'h3);
    apb(1'b0, 8'h00, 32'h0);
    chkB(rdE, 1'b1);
    cpuStop <= 1'b0;
    repeat (4) @(posedge clk);
    chkW(32'(modeOut), 32'h0);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, 8'h00, 32'h0);
    chkW(rdQ, 32'h2);
    conclude();
  end
  initial begin
    repeat (20000) @(posedge clk);
    badCount++;
    conclude();
  end
endmodule : cpm_top_tb
bind cpm_top cpm_top_monitor #(.INSTANCE(INSTANCE)) u_cpm_top_monitor (
  .clk, .rst, .psel, .penable, .pslverr, .cpuStop, .rxBusy, .txEmpty,
  .transmitPin, .sleepAck, .modeOut, .protoClkEn, .regClkEn, .deferAllow,
  .busOffCountEn, .wakeIrq, .timerCh4, .timerCh5, .bitTick);
`default_nettype wire
